// File: verification/adc_average_compare_tb_top.sv
// self-checking bench for the averaging and compare block
// assumes one 40 mhz clock, avalon-mm master driven from this bench
`timescale 1ns/10ps

module adc_average_compare_tb_top;
  import avg_cmp_pkg::*;

  // ==========================================================================
  // signals
  logic        ref_clk;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  sample_s     sample_in;
  logic        conv_busy;
  logic        low_power_mode;
  logic        conv_complete_flag;
  logic        conv_active_flag;
  logic        irq;
  logic        wake_irq;
  logic [31:0] rd_data;
  logic [15:0] last_res;
  int          err_total;
  int          cmp_count;

  adc_average_compare i_dut (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .sample_in          (sample_in),
    .conv_busy          (conv_busy),
    .low_power_mode     (low_power_mode),
    .conv_complete_flag (conv_complete_flag),
    .conv_active_flag   (conv_active_flag),
    .irq                (irq),
    .wake_irq           (wake_irq)
  );

  // 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // shared tasks
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  // waitrequest and read data are taken at the rising edge itself, before
  // the slave's own registers move, so the accepting edge is the one seen
  task automatic wait_ack();
    int i;
    i = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && i < 16) begin
      @(posedge ref_clk);
      i++;
    end
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      stop_test();
    end
    rd_data = avs_readdata;
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write     <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    d = rd_data;
    avs_read    <= 1'b0;
  endtask

  task automatic send(input logic [15:0] v);
    @(posedge ref_clk);
    sample_in <= '{valid: 1'b1, data: v};
    @(posedge ref_clk);
    sample_in.valid <= 1'b0;
  endtask

  // result and irq land on the same edge, two edges after the sample
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(OFF_CTRL, d);
    chk(d, 32'h0000_0000);
    bus_rd(OFF_TIMING, d);
    chk(d, 32'h0000_1405);
    bus_rd(OFF_IRQ_MASK, d);
    chk(d, 32'h0000_0001);
    bus_rd(OFF_CONVTIME, d);
    chk(d, 32'h0000_0019);
    bus_wr(6'h24, 32'hFFFF_FFFF);
    bus_rd(6'h24, d);
    chk(d, 32'h0000_0000);
    bus_wr(OFF_RESULT, 32'h0000_FFFF);
    bus_rd(OFF_RESULT, d);
    chk(d, 32'h0000_0000);
    // long and high-speed adders widen each conversion, 32 averaged
    bus_wr(OFF_TIMING, 32'h0203_1405);
    bus_wr(OFF_CTRL, 32'h0000_0007);
    bus_rd(OFF_CONVTIME, d);
    chk(d, 32'h0000_0325);
    bus_wr(OFF_TIMING, 32'h0000_1405);
    bus_wr(OFF_CTRL, 32'h0000_0000);
    conv_busy <= 1'b1;
    settle();
    chk(32'(conv_active_flag), 32'h0000_0001);
    @(posedge ref_clk);
    conv_busy <= 1'b0;
  endtask

  // masked event stays pending, unmasking raises the line, read clears
  task automatic t_single();
    logic [31:0] d;
    bus_wr(OFF_IRQ_MASK, 32'h0000_0000);
    bus_wr(OFF_CTRL, 32'h0000_0040);
    send(16'h1234);
    settle();
    chk(32'(conv_complete_flag), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    bus_wr(OFF_IRQ_MASK, 32'h0000_0001);
    settle();
    chk(32'(irq), 32'h0000_0001);
    bus_rd(OFF_RESULT, d);
    chk(d, 32'h0000_1234);
    bus_rd(OFF_IRQ_STAT, d);
    chk(d, 32'h0000_0001);
    settle();
    chk(32'(conv_complete_flag), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    last_res = 16'h1234;
  endtask

  // cfg holds range, greater and compare enable; samples are base+i
  task automatic run_avg(input logic [1:0] sel, input logic [2:0] cfg,
                         input logic [15:0] base, input logic lp,
                         input logic ld);
    logic [31:0] d;
    logic [31:0] sum;
    int          n;
    n = 4 << sel;
    sum = 0;
    bus_wr(OFF_CTRL, {25'h0, 1'b1, cfg, sel, 1'b1});
    low_power_mode <= lp;
    bus_rd(OFF_CONVTIME, d);
    chk(d, 32'(5 + n * 20));
    for (int i = 0; i < n; i++) begin
      send(base + 16'(i));
      sum = sum + 32'(base) + 32'(i);
      settle();
      if (i < n - 1) begin
        chk(32'(conv_complete_flag), 32'h0000_0000);
        chk(32'(conv_active_flag), 32'h0000_0001);
      end
    end
    chk(32'(conv_complete_flag), 32'(ld));
    chk(32'(irq), 32'(ld));
    chk(32'(wake_irq), 32'(ld & lp));
    if (ld) begin
      last_res = 16'(sum >> (2 + sel));
    end
    bus_rd(OFF_RESULT, d);
    chk(d, {16'h0, last_res});
    bus_rd(OFF_IRQ_STAT, d);
    chk(d, {29'h0, 1'b1, ~ld, ld});
    low_power_mode <= 1'b0;
    settle();
  endtask

  task automatic chk_cmp(input logic gt, input logic ren,
                         input logic [15:0] a, input logic [15:0] b,
                         input logic [15:0] v, input logic ok);
    logic [31:0] d;
    bus_wr(OFF_CTRL, {26'h0, ren, gt, 1'b1, 3'h0});
    bus_wr(OFF_CMP_A, {16'h0, a});
    bus_wr(OFF_CMP_B, {16'h0, b});
    send(v);
    settle();
    chk(32'(conv_complete_flag), 32'(ok));
    if (ok) begin
      last_res = v;
    end
    bus_rd(OFF_RESULT, d);
    chk(d, {16'h0, last_res});
    bus_rd(OFF_IRQ_STAT, d);
    chk(d, {30'h0, ~ok, 1'b0});
  endtask

  task automatic t_cmp();
    chk_cmp(1'b0, 1'b0, 16'h0064, 16'h0000, 16'h0063, 1'b1);
    chk_cmp(1'b0, 1'b0, 16'h0064, 16'h0000, 16'h0064, 1'b0);
    chk_cmp(1'b1, 1'b0, 16'h0064, 16'h0000, 16'h0064, 1'b1);
    chk_cmp(1'b1, 1'b0, 16'h0064, 16'h0000, 16'h0063, 1'b0);
    chk_cmp(1'b0, 1'b1, 16'h0064, 16'h00C8, 16'h0063, 1'b1);
    chk_cmp(1'b0, 1'b1, 16'h0064, 16'h00C8, 16'h00C9, 1'b1);
    chk_cmp(1'b0, 1'b1, 16'h0064, 16'h00C8, 16'h00C8, 1'b0);
    chk_cmp(1'b0, 1'b1, 16'h00C8, 16'h0064, 16'h0096, 1'b1);
    chk_cmp(1'b0, 1'b1, 16'h00C8, 16'h0064, 16'h0064, 1'b0);
    chk_cmp(1'b1, 1'b1, 16'h0064, 16'h00C8, 16'h0064, 1'b1);
    chk_cmp(1'b1, 1'b1, 16'h0064, 16'h00C8, 16'h00C8, 1'b1);
    chk_cmp(1'b1, 1'b1, 16'h0064, 16'h00C8, 16'h00C9, 1'b0);
    chk_cmp(1'b1, 1'b1, 16'h00C8, 16'h0064, 16'h00C8, 1'b1);
    chk_cmp(1'b1, 1'b1, 16'h00C8, 16'h0064, 16'h0064, 1'b1);
    chk_cmp(1'b1, 1'b1, 16'h00C8, 16'h0064, 16'h0096, 1'b0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst            = 1'b1;
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    sample_in      = '{valid: 1'b0, data: 16'h0000};
    conv_busy      = 1'b0;
    low_power_mode = 1'b0;
    last_res       = 16'h0000;
    err_total      = 0;
    cmp_count      = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    for (int s = 0; s < 4; s++) begin
      run_avg(2'(s), 3'h0, 16'h0100, 1'b0, 1'b1);
    end
    run_avg(2'h0, 3'h0, 16'h0200, 1'b1, 1'b1);
    // samples 98..101 average to 99: samples 100 and 101 alone would pass
    bus_wr(OFF_CMP_A, 32'h0000_0064);
    run_avg(2'h0, 3'h3, 16'h0062, 1'b0, 1'b0);
    bus_wr(OFF_CMP_A, 32'h0000_0063);
    run_avg(2'h0, 3'h3, 16'h0062, 1'b1, 1'b1);
    t_cmp();
    stop_test();
  end

endmodule

// File: verilog/adc_average_compare.sv
// averaging accumulator, threshold compare, result register and irq logic
// assumes converter samples arrive on ref_clk as one-cycle valid strobes
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - averaging enable selects 4, 8, 16, 32
// - active flag high during averaging sequence
// - accumulate samples, average after last one
// - no complete flag for inner conversions
// - end of sequence loads result, sets flag
// - interrupt when flag sets with enable
// - averaging continues in low power, wakes
// - less-than mode: result below value a
// - greater mode: result at/above value a
// - outside range exclusive when a<=b
// - inside range exclusive when a>b
// - inside range inclusive when a<=b
// - outside range inclusive when a>b
// - compare false: no flag, no load
// - compare applies to averaged value
// - compare monitors in low power, wakes
// - conversion time from adders and count
module adc_average_compare #(
  parameter int SAMPLE_W = avg_cmp_pkg::SAMPLE_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire avg_cmp_pkg::sample_s        sample_in,
  input  wire logic                        conv_busy,
  input  wire logic                        low_power_mode,
  output logic                             conv_complete_flag,
  output logic                             conv_active_flag,
  output logic                             irq,
  output logic                             wake_irq
);
  import avg_cmp_pkg::*;

  // ==========================================================================
  // registers
  ctrl_s                  ctrl_reg;
  timing_s                timing_reg;
  logic [SAMPLE_W-1:0]    cmp_value_a_reg;
  logic [SAMPLE_W-1:0]    cmp_value_b_reg;
  logic [SAMPLE_W-1:0]    result_reg;
  logic                   complete_reg;
  logic                   active_reg;
  logic [IRQ_BITS-1:0]    irq_stat_reg;
  logic [IRQ_BITS-1:0]    irq_mask_reg;
  logic                   ack_reg;
  logic [31:0]            rdata_reg;
  logic [IRQ_BITS-1:0]    rd_stat_cap_reg;
  logic                   rd_flag_cap_reg;
  logic [ACC_W-1:0]       acc_reg;
  logic [5:0]             cnt_reg;
  logic                   final_valid_reg;
  logic [SAMPLE_W-1:0]    final_value_reg;
  logic                   irq_reg;

  // ==========================================================================
  // combinational helpers
  logic                   req;
  logic                   bus_fire;
  logic                   wr_fire;
  logic                   rd_fire;
  logic [5:0]             avg_num;
  logic [2:0]             avg_shift;
  logic [ACC_W-1:0]       sum_next;
  logic [ACC_W-1:0]       sum_shifted;
  logic                   last_sample;
  logic                   cmp_pass;
  logic                   load_result;
  logic                   discard;
  logic [15:0]            conv_time;
  logic [9:0]             per_conv;
  logic [IRQ_BITS-1:0]    irq_set;

  // one wait state on every access: the request is taken on the second edge
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign bus_fire        = req & ack_reg;
  assign wr_fire         = bus_fire & avs_write;
  assign rd_fire         = bus_fire & avs_read;
  assign avs_readdata    = rdata_reg;

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // six compare modes from greater select, range enable and a vs b
  function automatic logic cmp_eval(input logic [SAMPLE_W-1:0] r,
                                    input logic [SAMPLE_W-1:0] a,
                                    input logic [SAMPLE_W-1:0] b,
                                    input logic                gt,
                                    input logic                ren);
    logic res;
    res = 1'b0;
    case ({gt, ren})
      2'b00: res = (r < a);
      2'b10: res = (r >= a);
      2'b01: begin
        if (a <= b) begin
          res = (r < a) || (r > b);
        end else begin
          res = (r < a) && (r > b);
        end
      end
      default: begin
        if (a <= b) begin
          res = (r >= a) && (r <= b);
        end else begin
          res = (r >= a) || (r <= b);
        end
      end
    endcase
    return res;
  endfunction

  // ==========================================================================
  // averaging datapath
  // count and shift follow the two-bit select: 4 << sel and 2 + sel
  assign avg_num     = AVG_MIN_NUM << ctrl_reg.avg_count_select;
  assign avg_shift   = AVG_MIN_SHIFT + {1'b0, ctrl_reg.avg_count_select};
  assign sum_next    = acc_reg + {{(ACC_W-SAMPLE_W){1'b0}}, sample_in.data};
  assign sum_shifted = sum_next >> avg_shift;
  assign last_sample = (cnt_reg == avg_num - 6'h01);

  // accumulator and count; clearing avg_enable abandons a partial sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (!ctrl_reg.avg_enable) begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (sample_in.valid) begin
      if (last_sample) begin
        acc_reg <= '0;
        cnt_reg <= '0;
      end else begin
        acc_reg <= sum_next;
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  // final value: the average, or each raw sample when averaging is off
  // truncating division keeps the shift free; no rounding is applied
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      final_valid_reg <= 1'b0;
      final_value_reg <= '0;
    end else begin
      final_valid_reg <= 1'b0;
      if (sample_in.valid && !ctrl_reg.avg_enable) begin
        final_valid_reg <= 1'b1;
        final_value_reg <= sample_in.data;
      end else if (sample_in.valid && last_sample) begin
        final_valid_reg <= 1'b1;
        final_value_reg <= sum_shifted[SAMPLE_W-1:0];
      end
    end
  end

  // active while the converter runs or a sequence is partly summed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= conv_busy | (cnt_reg != 6'h00);
    end
  end

  // ==========================================================================
  // compare and result load
  assign cmp_pass    = cmp_eval(final_value_reg, cmp_value_a_reg,
                                cmp_value_b_reg,
                                ctrl_reg.cmp_greater_select,
                                ctrl_reg.cmp_range_enable);
  assign load_result = final_valid_reg &
                       (~ctrl_reg.cmp_enable | cmp_pass);
  assign discard     = final_valid_reg & ctrl_reg.cmp_enable & ~cmp_pass;

  // result only moves on a passing value; a failing one is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_reg <= '0;
    end else if (load_result) begin
      result_reg <= final_value_reg;
    end
  end

  // complete flag: reading the result clears it, a new set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      complete_reg <= 1'b0;
    end else if (load_result) begin
      complete_reg <= 1'b1;
    end else if (rd_fire && avs_address == OFF_RESULT && rd_flag_cap_reg) begin
      complete_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt status, sticky; a read clears only the bits it returned
  assign irq_set[IRQ_COMPLETE] = load_result & ctrl_reg.conv_irq_enable;
  assign irq_set[IRQ_DISCARD]  = discard;
  assign irq_set[IRQ_AVG_DONE] = final_valid_reg & ctrl_reg.avg_enable;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (rd_fire && avs_address == OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~rd_stat_cap_reg) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // wake source is the same irq; processing ignores low_power_mode on
  // purpose so sequences and compares carry on through wait and stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |((irq_stat_reg | irq_set) & irq_mask_reg);
    end
  end

  assign irq                = irq_reg;
  assign wake_irq           = irq_reg & low_power_mode;
  assign conv_complete_flag = complete_reg;
  assign conv_active_flag   = active_reg;

  // ==========================================================================
  // conversion time estimate in converter clock cycles
  assign per_conv  = {2'b00, timing_reg.base_conv_time}
                   + {2'b00, timing_reg.long_sample_adder}
                   + {2'b00, timing_reg.high_speed_adder};
  always_comb begin
    conv_time = 16'h0000;
    if (ctrl_reg.avg_enable) begin
      conv_time = {6'h00, per_conv} << (avg_shift);
    end else begin
      conv_time = {6'h00, per_conv};
    end
    conv_time = conv_time + {8'h00, timing_reg.first_conv_adder};
  end

  // ==========================================================================
  // bus slave: writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg        <= '0;
      cmp_value_a_reg <= '0;
      cmp_value_b_reg <= '0;
      timing_reg      <= {HIGH_ADD_RST, LONG_ADD_RST,
                          BASE_TIME_RST, FIRST_ADD_RST};
      irq_mask_reg    <= IRQ_MASK_RST;
    end else if (wr_fire) begin
      if (avs_address == OFF_CTRL) begin
        ctrl_reg <= ctrl_s'(merge(32'(ctrl_reg), avs_writedata,
                                  avs_byteenable));
      end else if (avs_address == OFF_CMP_A) begin
        cmp_value_a_reg <= SAMPLE_W'(merge(32'(cmp_value_a_reg),
                                           avs_writedata, avs_byteenable));
      end else if (avs_address == OFF_CMP_B) begin
        cmp_value_b_reg <= SAMPLE_W'(merge(32'(cmp_value_b_reg),
                                           avs_writedata, avs_byteenable));
      end else if (avs_address == OFF_TIMING) begin
        timing_reg <= timing_s'(merge(timing_reg, avs_writedata,
                                      avs_byteenable));
      end else if (avs_address == OFF_IRQ_MASK) begin
        irq_mask_reg <= IRQ_BITS'(merge(32'(irq_mask_reg), avs_writedata,
                                        avs_byteenable));
      end
    end
  end

  // ==========================================================================
  // bus slave: reads, captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      rdata_reg       <= 32'h0000_0000;
      rd_stat_cap_reg <= '0;
      rd_flag_cap_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        rd_stat_cap_reg <= irq_stat_reg;
        rd_flag_cap_reg <= complete_reg;
        if (avs_address == OFF_CTRL) begin
          rdata_reg <= 32'(ctrl_reg);
        end else if (avs_address == OFF_CMP_A) begin
          rdata_reg <= 32'(cmp_value_a_reg);
        end else if (avs_address == OFF_CMP_B) begin
          rdata_reg <= 32'(cmp_value_b_reg);
        end else if (avs_address == OFF_RESULT) begin
          rdata_reg <= 32'(result_reg);
        end else if (avs_address == OFF_STATUS) begin
          rdata_reg <= {30'h0000_0000, active_reg, complete_reg};
        end else if (avs_address == OFF_TIMING) begin
          rdata_reg <= timing_reg;
        end else if (avs_address == OFF_CONVTIME) begin
          rdata_reg <= {16'h0000, conv_time};
        end else if (avs_address == OFF_IRQ_STAT) begin
          rdata_reg <= 32'(irq_stat_reg);
        end else if (avs_address == OFF_IRQ_MASK) begin
          rdata_reg <= 32'(irq_mask_reg);
        end else begin
          rdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // checks
  chk_avg_count_bound: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrl_reg.avg_enable |-> (cnt_reg < avg_num))
    else $error("averaging count ran past the selected number");

  chk_active_during_seq: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cnt_reg != 6'h00) |=> active_reg)
    else $error("active flag low inside an averaging sequence");

  chk_accum_last_done: assert property (
    @(posedge ref_clk) disable iff (rst)
    (sample_in.valid && ctrl_reg.avg_enable && last_sample)
    |=> final_valid_reg && acc_reg == '0 && cnt_reg == 6'h00)
    else $error("sequence end did not produce an average");

  chk_no_inner_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    (sample_in.valid && ctrl_reg.avg_enable && !last_sample)
    |=> !final_valid_reg && !load_result)
    else $error("inner conversion reached the result stage");

  chk_result_load: assert property (
    @(posedge ref_clk) disable iff (rst)
    load_result |=> complete_reg && result_reg == $past(final_value_reg))
    else $error("passing value not loaded with flag set");

  chk_no_load_fail: assert property (
    @(posedge ref_clk) disable iff (rst)
    (final_valid_reg && ctrl_reg.cmp_enable && !cmp_pass && !complete_reg)
    |=> $stable(result_reg) && !complete_reg)
    else $error("failing compare changed result or flag");

  chk_irq_on_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    (load_result && ctrl_reg.conv_irq_enable && irq_mask_reg[IRQ_COMPLETE])
    |=> irq)
    else $error("interrupt missing after flag set");

  chk_cmp_less_mode: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!ctrl_reg.cmp_greater_select && !ctrl_reg.cmp_range_enable)
    |-> cmp_pass == (final_value_reg < cmp_value_a_reg))
    else $error("less-than compare mode wrong");

  chk_cmp_inside_incl: assert property (
    @(posedge ref_clk) disable iff (rst)
    (ctrl_reg.cmp_greater_select && ctrl_reg.cmp_range_enable
     && cmp_value_a_reg <= cmp_value_b_reg)
    |-> cmp_pass == (final_value_reg >= cmp_value_a_reg
                     && final_value_reg <= cmp_value_b_reg))
    else $error("inclusive inside range compare wrong");

  chk_wake_in_stop: assert property (
    @(posedge ref_clk) disable iff (rst)
    (low_power_mode && irq) |-> wake_irq)
    else $error("wake not raised in low power mode");

endmodule

// File: verilog/avg_cmp_pkg.sv
// constants, field layouts and carriers for the averaging and compare block
// assumes a 32-bit avalon-mm register bus and one 40 mhz clock
package avg_cmp_pkg;

  // ==========================================================================
  // widths and timing
  localparam int          SAMPLE_W     = 16;
  localparam int          ACC_W        = SAMPLE_W + 5;   // room for 32 sums
  localparam int          CLK_PERIOD_NS = 25;

  // ==========================================================================
  // register byte offsets
  localparam logic [5:0]  OFF_CTRL     = 6'h00;
  localparam logic [5:0]  OFF_CMP_A    = 6'h04;
  localparam logic [5:0]  OFF_CMP_B    = 6'h08;
  localparam logic [5:0]  OFF_RESULT   = 6'h0C;
  localparam logic [5:0]  OFF_STATUS   = 6'h10;
  localparam logic [5:0]  OFF_TIMING   = 6'h14;
  localparam logic [5:0]  OFF_CONVTIME = 6'h18;
  localparam logic [5:0]  OFF_IRQ_STAT = 6'h1C;
  localparam logic [5:0]  OFF_IRQ_MASK = 6'h20;

  // ==========================================================================
  // interrupt status bit positions
  localparam int          IRQ_BITS     = 3;
  localparam int          IRQ_COMPLETE = 0;  // result loaded, flag set
  localparam int          IRQ_DISCARD  = 1;  // compare false, result dropped
  localparam int          IRQ_AVG_DONE = 2;  // averaging sequence finished

  // ==========================================================================
  // reset values
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 3'h1;
  localparam logic [7:0]  FIRST_ADD_RST = 8'h05;
  localparam logic [7:0]  BASE_TIME_RST = 8'h14;
  localparam logic [7:0]  LONG_ADD_RST  = 8'h00;
  localparam logic [7:0]  HIGH_ADD_RST  = 8'h00;
  localparam logic [5:0]  AVG_MIN_NUM   = 6'h04;
  localparam logic [2:0]  AVG_MIN_SHIFT = 3'h2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       conv_irq_enable;
    logic       cmp_range_enable;
    logic       cmp_greater_select;
    logic       cmp_enable;
    logic [1:0] avg_count_select;
    logic       avg_enable;
  } ctrl_s;

  typedef struct packed {
    logic [7:0] high_speed_adder;
    logic [7:0] long_sample_adder;
    logic [7:0] base_conv_time;
    logic [7:0] first_conv_adder;
  } timing_s;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } sample_s;

endpackage
